// ---- core/sbcd_cfg.svh ----
// Purpose: constants for the secondary bus command decoder
// Assumes: included by bare name from the command class and top design files
// Notes: command codes, address field positions, header layout
`ifndef SBCD_CFG_SVH
`define SBCD_CFG_SVH

// ****************************************
// command codes
// ****************************************
`define SBCD_CMD_INTACK 4'h0
`define SBCD_CMD_SPECIAL 4'h1
`define SBCD_CMD_IO_RD 4'h2
`define SBCD_CMD_IO_WR 4'h3
`define SBCD_CMD_MEM_RD 4'h6
`define SBCD_CMD_MEM_WR 4'h7
`define SBCD_CMD_CFG_RD 4'hA
`define SBCD_CMD_CFG_WR 4'hB
`define SBCD_CMD_MEM_RD_MUL 4'hC
`define SBCD_CMD_DAC 4'hD
`define SBCD_CMD_MEM_RD_LINE 4'hE
`define SBCD_CMD_MEM_WR_INV 4'hF

// ****************************************
// configuration address fields
// ****************************************
`define SBCD_CFG_TYPE_F 1:0
`define SBCD_CFG_TYPE0 2'h0
`define SBCD_CFG_TYPE1 2'h1
`define SBCD_CFG_FN_F 10:8
`define SBCD_CFG_DEV_F 15:11
`define SBCD_CFG_BUS_F 23:16
`define SBCD_SC_DEV 5'h1F
`define SBCD_SC_FN 3'h7

// ****************************************
// configuration header layout
// ****************************************
`define SBCD_HDR_BYTES 64
`define SBCD_HDR_WORDS 16
`define SBCD_ID_IDX 4'h0
`define SBCD_CLASS_IDX 4'h2
`define SBCD_BUSNUM_IDX 4'h6
`define SBCD_PRI_BUS_F 7:0
`define SBCD_SEC_BUS_F 15:8
`define SBCD_SUB_BUS_F 23:16
`define SBCD_HDR_RESET 32'h0000_0000

`endif

// ---- core/sbcd_pkg.sv ----
// Purpose: types for the secondary bus command decoder
// Assumes: used only by package-qualified names
// Notes: states are one-hot
package sbcd_pkg;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_DAC = 4'h2,
		ST_DECIDE = 4'h4,
		ST_BUSY = 4'h8
	} sbcd_state_t;

	typedef enum logic [2:0] {
		CL_IGNORE = 3'h0,
		CL_SPECIAL = 3'h1,
		CL_IO = 3'h2,
		CL_MEM = 3'h3,
		CL_CFGWR = 3'h4
	} sbcd_class_t;

	typedef enum logic [1:0] {
		KIND_IO = 2'h0,
		KIND_MEM = 2'h1,
		KIND_SPECIAL = 2'h2,
		KIND_TYPE1 = 2'h3
	} sbcd_kind_t;

endpackage

// ---- core/sbcd_cmd_class.sv ----
// Purpose: sorts a bus command code into a decode class
// Assumes: code is stable while the class is used
// Notes: purely combinational
`timescale 1ns/100ps
`include "sbcd_cfg.svh"

module sbcd_cmd_class (
	// command in
	input wire logic [3:0] i_cmd,
	// class out
	output sbcd_pkg::sbcd_class_t o_class
);

	always_comb begin
		case (i_cmd)
			`SBCD_CMD_SPECIAL: o_class = sbcd_pkg::CL_SPECIAL;
			`SBCD_CMD_IO_RD,
			`SBCD_CMD_IO_WR: o_class = sbcd_pkg::CL_IO;
			`SBCD_CMD_MEM_RD,
			`SBCD_CMD_MEM_WR,
			`SBCD_CMD_MEM_RD_MUL,
			`SBCD_CMD_MEM_RD_LINE,
			`SBCD_CMD_MEM_WR_INV: o_class = sbcd_pkg::CL_MEM;
			`SBCD_CMD_CFG_WR: o_class = sbcd_pkg::CL_CFGWR;
			// interrupt acknowledge, config read, reserved and a nested dac
			default: o_class = sbcd_pkg::CL_IGNORE;
		endcase
	end

endmodule // sbcd_cmd_class

// ---- core/sbcd_bus_range.sv ----
// Purpose: tests whether a bus number lies in an inclusive range
// Assumes: low bound not above high bound when software set it up
// Notes: an inverted range matches nothing
`timescale 1ns/100ps

module sbcd_bus_range (
	// operands
	input wire logic [7:0] i_bus,
	input wire logic [7:0] i_low,
	input wire logic [7:0] i_high,
	// result
	output logic o_in_range
);

	assign o_in_range = (i_bus >= i_low) && (i_bus <= i_high);

endmodule // sbcd_bus_range

// ---- core/sbcd_top.sv ----
// Purpose: decides which secondary bus commands the bridge claims and forwards
// Assumes: window decode logic answers the lookup in the same cycle
// Notes: pins are synchronised, so a decision lands four edges after frame start, five for a dual address cycle
`timescale 1ns/100ps
`include "sbcd_cfg.svh"

module sbcd_top #(
	parameter logic [15:0] VENDOR_CODE = 16'h0A5A, // arbitrary value
	parameter logic [15:0] DEVICE_CODE = 16'h0C3C, // arbitrary value
	parameter logic [7:0] REVISION_CODE = 8'h01, // arbitrary value
	parameter logic [23:0] CLASS_CODE = 24'h000000
) (
	// clock and reset
	input wire logic I_CORE_CLK,
	input wire logic I_RST,
	// secondary bus pins
	input wire logic I_SEC_FRAME_N,
	input wire logic [31:0] I_SEC_AD,
	input wire logic [3:0] I_SECONDARY_CMD_BYTE_ENABLE,
	// window lookup
	output logic O_LOOKUP_VALID,
	output logic [3:0] O_LOOKUP_CMD,
	output logic [63:0] O_LOOKUP_ADDR,
	input wire logic I_IO_HIT,
	input wire logic I_MEM_HIT,
	// forward request
	output logic O_CLAIM,
	output sbcd_pkg::sbcd_kind_t O_FWD_KIND,
	output logic [3:0] O_FWD_CMD,
	output logic [63:0] O_FWD_ADDR,
	output logic O_FWD_DAC,
	// header access
	input wire logic I_CFG_WR,
	input wire logic [3:0] I_CFG_IDX,
	input wire logic [3:0] I_CFG_BE,
	input wire logic [31:0] I_CFG_WDATA,
	output logic [31:0] O_CFG_RDATA
);

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic frame_s1_r;
	logic frame_s2_r;
	logic frame_prev_r;
	logic [31:0] ad_s1_r;
	logic [31:0] ad_s2_r;
	logic [3:0] cbe_s1_r;
	logic [3:0] cbe_s2_r;
	logic frame_start;

	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			frame_s1_r <= 1'b1;
			frame_s2_r <= 1'b1;
			frame_prev_r <= 1'b1;
		end else begin
			frame_s1_r <= I_SEC_FRAME_N;
			frame_s2_r <= frame_s1_r;
			frame_prev_r <= frame_s2_r;
		end
	end

	// address and command lanes travel with frame, same two-stage delay
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			ad_s1_r <= 32'h0000_0000;
			ad_s2_r <= 32'h0000_0000;
			cbe_s1_r <= 4'h0;
			cbe_s2_r <= 4'h0;
		end else begin
			ad_s1_r <= I_SEC_AD;
			ad_s2_r <= ad_s1_r;
			cbe_s1_r <= I_SECONDARY_CMD_BYTE_ENABLE;
			cbe_s2_r <= cbe_s1_r;
		end
	end

	assign frame_start = frame_prev_r && !frame_s2_r;

	// ****************************************
	// configuration header
	// ****************************************
	logic [31:0] hdr_r [0:`SBCD_HDR_WORDS-1];
	logic [31:0] cfg_rdata_r;
	logic [7:0] pri_bus;
	logic [7:0] sec_bus;
	logic [7:0] sub_bus;

	// identity words are read-only; the rest take byte-enabled writes
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			for (int w = 0; w < `SBCD_HDR_WORDS; w++) begin
				hdr_r[w] <= `SBCD_HDR_RESET;
			end
		end else if (I_CFG_WR && I_CFG_IDX != `SBCD_ID_IDX && I_CFG_IDX != `SBCD_CLASS_IDX) begin
			for (int b = 0; b < 4; b++) begin
				if (I_CFG_BE[b]) begin
					hdr_r[I_CFG_IDX][b*8 +: 8] <= I_CFG_WDATA[b*8 +: 8];
				end
			end
		end
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			cfg_rdata_r <= 32'h0000_0000;
		end else begin
			case (I_CFG_IDX)
				`SBCD_ID_IDX: cfg_rdata_r <= {DEVICE_CODE, VENDOR_CODE};
				`SBCD_CLASS_IDX: cfg_rdata_r <= {CLASS_CODE, REVISION_CODE};
				default: cfg_rdata_r <= hdr_r[I_CFG_IDX];
			endcase
		end
	end

	assign O_CFG_RDATA = cfg_rdata_r;
	assign pri_bus = hdr_r[`SBCD_BUSNUM_IDX][`SBCD_PRI_BUS_F];
	assign sec_bus = hdr_r[`SBCD_BUSNUM_IDX][`SBCD_SEC_BUS_F];
	assign sub_bus = hdr_r[`SBCD_BUSNUM_IDX][`SBCD_SUB_BUS_F];

	// ****************************************
	// transaction capture
	// ****************************************
	sbcd_pkg::sbcd_state_t st_r;
	sbcd_pkg::sbcd_state_t st_nxt;
	logic [3:0] cmd_r;
	logic [31:0] addr_lo_r;
	logic [31:0] addr_hi_r;
	logic dac_r;

	always_comb begin
		st_nxt = st_r;
		case (st_r)
			sbcd_pkg::ST_IDLE: begin
				if (frame_start && cbe_s2_r == `SBCD_CMD_DAC) begin
					st_nxt = sbcd_pkg::ST_DAC;
				end else if (frame_start) begin
					st_nxt = sbcd_pkg::ST_DECIDE;
				end
			end
			sbcd_pkg::ST_DAC: begin
				// a frame that dies in the second address phase is dropped
				st_nxt = frame_s2_r ? sbcd_pkg::ST_IDLE : sbcd_pkg::ST_DECIDE;
			end
			sbcd_pkg::ST_DECIDE: st_nxt = sbcd_pkg::ST_BUSY;
			sbcd_pkg::ST_BUSY: st_nxt = frame_s2_r ? sbcd_pkg::ST_IDLE : sbcd_pkg::ST_BUSY;
			default: st_nxt = sbcd_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			st_r <= sbcd_pkg::ST_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// dac carries the low address first, then the high address and real command
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			cmd_r <= 4'h0;
			addr_lo_r <= 32'h0000_0000;
			addr_hi_r <= 32'h0000_0000;
			dac_r <= 1'b0;
		end else if (st_r == sbcd_pkg::ST_IDLE && frame_start) begin
			cmd_r <= cbe_s2_r;
			addr_lo_r <= ad_s2_r;
			addr_hi_r <= 32'h0000_0000;
			dac_r <= (cbe_s2_r == `SBCD_CMD_DAC);
		end else if (st_r == sbcd_pkg::ST_DAC) begin
			cmd_r <= cbe_s2_r;
			addr_hi_r <= ad_s2_r;
		end
	end

	assign O_LOOKUP_VALID = (st_r == sbcd_pkg::ST_DECIDE);
	assign O_LOOKUP_CMD = cmd_r;
	assign O_LOOKUP_ADDR = {addr_hi_r, addr_lo_r};

	// ****************************************
	// decode decision
	// ****************************************
	sbcd_pkg::sbcd_class_t cls;
	logic tgt_in_range;
	logic is_type0;
	logic is_type1;
	logic sc_req;
	logic claim_nxt;
	sbcd_pkg::sbcd_kind_t kind_nxt;
	logic [3:0] fwd_cmd_nxt;
	logic claim_r;
	sbcd_pkg::sbcd_kind_t kind_r;
	logic [3:0] fwd_cmd_r;
	logic [63:0] fwd_addr_r;
	logic fwd_dac_r;

	sbcd_cmd_class u_cmd_class (
		.i_cmd(cmd_r),
		.o_class(cls)
	);

	sbcd_bus_range u_bus_range (
		.i_bus(addr_lo_r[`SBCD_CFG_BUS_F]),
		.i_low(sec_bus),
		.i_high(sub_bus),
		.o_in_range(tgt_in_range)
	);

	assign is_type0 = (addr_lo_r[`SBCD_CFG_TYPE_F] == `SBCD_CFG_TYPE0);
	assign is_type1 = (addr_lo_r[`SBCD_CFG_TYPE_F] == `SBCD_CFG_TYPE1);
	assign sc_req = is_type1 && addr_lo_r[`SBCD_CFG_DEV_F] == `SBCD_SC_DEV
		&& addr_lo_r[`SBCD_CFG_FN_F] == `SBCD_SC_FN;

	always_comb begin
		claim_nxt = 1'b0;
		kind_nxt = sbcd_pkg::KIND_MEM;
		fwd_cmd_nxt = cmd_r;
		if (st_r == sbcd_pkg::ST_DECIDE) begin
			case (cls)
				sbcd_pkg::CL_IO: begin
					// io space has no 64-bit form, so io after dac is dropped
					claim_nxt = I_IO_HIT && !dac_r;
					kind_nxt = sbcd_pkg::KIND_IO;
				end
				sbcd_pkg::CL_MEM: begin
					claim_nxt = I_MEM_HIT;
					kind_nxt = sbcd_pkg::KIND_MEM;
				end
				sbcd_pkg::CL_CFGWR: begin
					if (sc_req && !dac_r) begin
						if (addr_lo_r[`SBCD_CFG_BUS_F] == pri_bus) begin
							claim_nxt = 1'b1;
							kind_nxt = sbcd_pkg::KIND_SPECIAL;
							fwd_cmd_nxt = `SBCD_CMD_SPECIAL;
						end else if (!tgt_in_range) begin
							claim_nxt = 1'b1;
							kind_nxt = sbcd_pkg::KIND_TYPE1;
							fwd_cmd_nxt = `SBCD_CMD_CFG_WR;
						end else begin
							claim_nxt = 1'b0;
						end
					end else begin
						claim_nxt = 1'b0;
					end
				end
				sbcd_pkg::CL_SPECIAL: claim_nxt = 1'b0;
				default: claim_nxt = 1'b0;
			endcase
		end
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			claim_r <= 1'b0;
		end else begin
			claim_r <= claim_nxt;
		end
	end

	// forward fields only move on a claim, so they hold for the forwarding logic
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			kind_r <= sbcd_pkg::KIND_MEM;
			fwd_cmd_r <= 4'h0;
			fwd_addr_r <= 64'h0000_0000_0000_0000;
			fwd_dac_r <= 1'b0;
		end else if (claim_nxt) begin
			kind_r <= kind_nxt;
			fwd_cmd_r <= fwd_cmd_nxt;
			fwd_addr_r <= {addr_hi_r, addr_lo_r};
			fwd_dac_r <= dac_r;
		end
	end

	assign O_CLAIM = claim_r;
	assign O_FWD_KIND = kind_r;
	assign O_FWD_CMD = fwd_cmd_r;
	assign O_FWD_ADDR = fwd_addr_r;
	assign O_FWD_DAC = fwd_dac_r;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (I_RST);

	sequence in_decide;
		st_r == sbcd_pkg::ST_DECIDE;
	endsequence

	sequence dac_start;
		st_r == sbcd_pkg::ST_IDLE && frame_start && cbe_s2_r == `SBCD_CMD_DAC;
	endsequence

	sequence dac_walk;
		st_r == sbcd_pkg::ST_DAC ##1 st_r == sbcd_pkg::ST_DECIDE ##1 st_r == sbcd_pkg::ST_BUSY;
	endsequence

	special_no_claim_a: assert property (
		in_decide ##0 cmd_r == `SBCD_CMD_SPECIAL |=> !O_CLAIM)
		else $error("special cycle was claimed");

	io_claim_a: assert property (
		in_decide ##0 (cmd_r == `SBCD_CMD_IO_RD || cmd_r == `SBCD_CMD_IO_WR) ##0 !dac_r
		|=> O_CLAIM == $past(I_IO_HIT) && (!O_CLAIM || O_FWD_KIND == sbcd_pkg::KIND_IO))
		else $error("io command claim does not follow io window hit");

	mem_claim_a: assert property (
		in_decide ##0 (cmd_r == `SBCD_CMD_MEM_WR || cmd_r == `SBCD_CMD_MEM_RD_MUL
		|| cmd_r == `SBCD_CMD_MEM_RD_LINE || cmd_r == `SBCD_CMD_MEM_WR_INV)
		|=> O_CLAIM == $past(I_MEM_HIT))
		else $error("memory command claim does not follow memory window hit");

	type0_ignore_a: assert property (
		in_decide ##0 cmd_r == `SBCD_CMD_CFG_WR && is_type0 |=> !O_CLAIM)
		else $error("type 0 config write was claimed");

	type1_ignore_a: assert property (
		in_decide ##0 cmd_r == `SBCD_CMD_CFG_WR && is_type1 && !sc_req |=> !O_CLAIM)
		else $error("plain type 1 config write was claimed");

	sc_primary_a: assert property (
		in_decide ##0 cmd_r == `SBCD_CMD_CFG_WR && sc_req && !dac_r
		&& addr_lo_r[`SBCD_CFG_BUS_F] == pri_bus
		|=> O_CLAIM && O_FWD_KIND == sbcd_pkg::KIND_SPECIAL && O_FWD_CMD == `SBCD_CMD_SPECIAL)
		else $error("special cycle request to primary bus not regenerated");

	sc_upstream_a: assert property (
		in_decide ##0 cmd_r == `SBCD_CMD_CFG_WR && sc_req && !dac_r
		&& addr_lo_r[`SBCD_CFG_BUS_F] != pri_bus
		&& (addr_lo_r[`SBCD_CFG_BUS_F] < sec_bus || addr_lo_r[`SBCD_CFG_BUS_F] > sub_bus)
		|=> O_CLAIM && O_FWD_KIND == sbcd_pkg::KIND_TYPE1 && O_FWD_ADDR[31:0] == $past(addr_lo_r))
		else $error("special cycle request upstream not forwarded unchanged");

	sc_in_range_a: assert property (
		in_decide ##0 cmd_r == `SBCD_CMD_CFG_WR && sc_req && addr_lo_r[`SBCD_CFG_BUS_F] != pri_bus
		&& addr_lo_r[`SBCD_CFG_BUS_F] >= sec_bus && addr_lo_r[`SBCD_CFG_BUS_F] <= sub_bus
		|=> !O_CLAIM)
		else $error("special cycle request below bridge was claimed");

	dac_path_a: assert property (
		dac_start ##1 !frame_s2_r |-> dac_walk)
		else $error("dual address cycle did not reach decision");

	id_read_a: assert property (
		I_CFG_IDX == `SBCD_ID_IDX |=> O_CFG_RDATA == {DEVICE_CODE, VENDOR_CODE})
		else $error("identity word read back wrong");

	claim_once_a: assert property (
		O_CLAIM |=> !O_CLAIM [*2])
		else $error("claim pulse longer than one cycle");

endmodule // sbcd_top

// ---- bench/sbcd_init_model.sv ----
// Purpose: secondary bus initiator plus the window lookup that answers the decoder
// Assumes: one address phase, or two for a dual address cycle, then four data phases
// Notes: released lines carry a changing pattern so stale values never pass for driven ones
`timescale 1ns/100ps

module sbcd_init_model (
	// clock
	input wire logic clk,
	// lookup side
	input wire logic lookup_valid,
	input wire logic want_hit,
	output logic io_hit,
	output logic mem_hit,
	// secondary bus pins
	output logic frame_n,
	output logic [31:0] ad,
	output logic [3:0] cbe
);
	logic noise;

	initial begin
		frame_n = 1'h1;
		ad = 32'h5A5A_A5A5;
		cbe = 4'h0;
		noise = 1'h0;
	end

	// hit lines only mean something during lookup, so they toggle elsewhere
	always @(posedge clk) begin
		noise <= ~noise;
	end
	assign io_hit = lookup_valid ? want_hit : noise;
	assign mem_hit = lookup_valid ? want_hit : ~noise;

	task automatic run(input logic [3:0] c, input logic [31:0] lo, input logic [31:0] hi,
		input logic d);
		@(posedge clk);
		#1;
		frame_n = 1'h0;
		ad = lo;
		cbe = d ? 4'hD : c;
		if (d) begin
			@(posedge clk);
			#1;
			ad = hi;
			cbe = c;
		end
		repeat (4) begin
			@(posedge clk);
			#1;
			ad = $urandom;
			cbe = 4'($urandom);
		end
		frame_n = 1'h1;
		repeat (6) begin
			@(posedge clk);
			#1;
			ad = ~ad;
			cbe = ~cbe;
		end
	endtask
endmodule // sbcd_init_model

// ---- bench/tb_top.sv ----
// Purpose: self-checking bench for the secondary bus command decoder
// Assumes: design defaults for identity parameters
// Notes: random traffic from a fixed seed mixed with corner cases
`timescale 1ns/100ps

module tb_top;
	logic clk, rst, wr, want_hit, frame_n, io_hit, mem_hit, lv, claim, fdac;
	logic [3:0] idx, be, cbe, lcmd, fcmd, look_cmd;
	logic [31:0] wdata, rdata, ad, r, w;
	logic [63:0] laddr, faddr, look_addr;
	logic [7:0] pri, sec, sub;
	sbcd_pkg::sbcd_kind_t kind;
	int n_mismatch, compares, n_claim, n_look;

	sbcd_top DUT (.I_CORE_CLK(clk), .I_RST(rst), .I_SEC_FRAME_N(frame_n), .I_SEC_AD(ad),
		.I_SECONDARY_CMD_BYTE_ENABLE(cbe), .O_LOOKUP_VALID(lv), .O_LOOKUP_CMD(lcmd),
		.O_LOOKUP_ADDR(laddr), .I_IO_HIT(io_hit), .I_MEM_HIT(mem_hit), .O_CLAIM(claim),
		.O_FWD_KIND(kind), .O_FWD_CMD(fcmd), .O_FWD_ADDR(faddr), .O_FWD_DAC(fdac),
		.I_CFG_WR(wr), .I_CFG_IDX(idx), .I_CFG_BE(be), .I_CFG_WDATA(wdata),
		.O_CFG_RDATA(rdata));

	sbcd_init_model u_init (.clk(clk), .lookup_valid(lv), .want_hit(want_hit),
		.io_hit(io_hit), .mem_hit(mem_hit), .frame_n(frame_n), .ad(ad), .cbe(cbe));

	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		if (claim === 1'h1) n_claim++;
		if (lv === 1'h1) begin
			n_look++;
			look_cmd = lcmd;
			look_addr = laddr;
		end
	end

	task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	task automatic cfg_write(input logic [3:0] i, input logic [3:0] b, input logic [31:0] d);
		@(posedge clk);
		#1;
		wr = 1'h1;
		idx = i;
		be = b;
		wdata = d;
		@(posedge clk);
		#1;
		wr = 1'h0;
	endtask

	task automatic cfg_read(input logic [3:0] i, output logic [31:0] d);
		@(posedge clk);
		#1;
		idx = i;
		@(posedge clk);
		#1;
		d = rdata;
	endtask

	task automatic set_bus(input logic [7:0] p, input logic [7:0] s, input logic [7:0] u);
		pri = p;
		sec = s;
		sub = u;
		cfg_write(4'h6, 4'hF, {8'h00, u, s, p});
	endtask

	// returns {claim, kind, forwarded command}
	function automatic logic [6:0] exp_fwd(input logic [3:0] c, input logic [31:0] a,
		input logic d, input logic h);
		logic mem;
		logic sc;
		mem = c inside {4'h6, 4'h7, 4'hC, 4'hE, 4'hF};
		sc = c == 4'hB && a[1:0] == 2'h1 && a[15:11] == 5'h1F && a[10:8] == 3'h7;
		if (mem && h) return {1'h1, 2'h1, c};
		if (d) return 7'h00;
		if ((c == 4'h2 || c == 4'h3) && h) return {1'h1, 2'h0, c};
		if (sc && a[23:16] == pri) return {1'h1, 2'h2, 4'h1};
		if (sc && !(a[23:16] >= sec && a[23:16] <= sub)) return {1'h1, 2'h3, 4'hB};
		return 7'h00;
	endfunction

	function automatic logic [31:0] sc_addr(input logic [7:0] bus);
		return {8'h00, bus, 8'hFF, 8'h01};
	endfunction

	task automatic xact(input logic [3:0] c, input logic [31:0] lo, input logic [31:0] hi,
		input logic d, input logic h);
		logic dual;
		logic [6:0] e;
		logic [1:0] k0;
		logic [63:0] a0;
		// a dac code in the first phase always opens a second address phase
		dual = d || c == 4'hD;
		e = exp_fwd(c, lo, dual, h);
		k0 = kind;
		a0 = faddr;
		want_hit = h;
		n_claim = 0;
		n_look = 0;
		u_init.run(c, lo, hi, dual);
		check("claim count", n_claim, e[6]);
		check("lookup count", n_look, 1);
		check("lookup cmd", look_cmd, c);
		check("lookup addr", look_addr, {dual ? hi : 32'h0, lo});
		if (e[6]) begin
			check("fwd kind", kind, e[5:4]);
			check("fwd cmd", fcmd, e[3:0]);
			check("fwd dac", fdac, dual);
			if (e[5:4] != 2'h2) check("fwd addr", faddr, {dual ? hi : 32'h0, lo});
		end else begin
			check("kept kind", kind, k0);
			check("kept addr", faddr, a0);
		end
	endtask

	initial begin
		#200000;
		n_mismatch++;
		$display("watchdog expired");
		report_and_stop();
	end

	initial begin
		rst = 1'h1;
		wr = 1'h0;
		idx = 4'h0;
		be = 4'h0;
		wdata = 32'h0;
		want_hit = 1'h0;
		n_mismatch = 0;
		compares = 0;
		n_claim = 0;
		n_look = 0;
		pri = 8'h00;
		sec = 8'h00;
		sub = 8'h00;
		void'($urandom(63475));
		repeat (5) @(posedge clk);
		#1;
		rst = 1'h0;
		// reset values and identity words
		check("claim at reset", claim, 1'h0);
		check("kind at reset", kind, 2'h1);
		cfg_read(4'h0, r);
		check("id word", r, {16'h0C3C, 16'h0A5A});
		cfg_read(4'h2, r);
		check("class word", r, {24'h000000, 8'h01});
		cfg_read(4'h6, r);
		check("bus word reset", r, 32'h0);
		$display("test reset done");
		// header storage: read-only identity, plain words, byte lanes
		cfg_write(4'h0, 4'hF, 32'hFFFF_FFFF);
		cfg_read(4'h0, r);
		check("id after write", r, {16'h0C3C, 16'h0A5A});
		for (int i = 1; i < 16; i++) begin
			if (i == 2) continue;
			w = $urandom;
			cfg_write(i[3:0], 4'hF, w);
			cfg_read(i[3:0], r);
			check("header word", r, w);
		end
		cfg_write(4'h5, 4'hF, 32'h0);
		cfg_write(4'h5, 4'h5, 32'hAABB_CCDD);
		cfg_read(4'h5, r);
		check("byte lanes", r, 32'h00BB_00DD);
		$display("test header done");
		// every command code, with and without hit, single and dual address
		set_bus(8'h10, 8'h20, 8'h2F);
		for (int c = 0; c < 16; c++) begin
			for (int k = 0; k < 4; k++) begin
				xact(c[3:0], $urandom, $urandom, k[1], k[0]);
			end
		end
		$display("test commands done");
		// special cycle requests at range edges and near misses
		for (int j = 0; j < 7; j++) begin
			logic [7:0] b;
			b = j == 0 ? 8'h10 : j == 1 ? 8'h20 : j == 2 ? 8'h2F : j == 3 ? 8'h30 :
				j == 4 ? 8'h1F : j == 5 ? 8'h25 : 8'h00;
			xact(4'hB, sc_addr(b), 32'h0, 1'h0, 1'h0);
		end
		xact(4'hB, sc_addr(8'h30) ^ 32'h0800, 32'h0, 1'h0, 1'h1);
		xact(4'hB, sc_addr(8'h30) ^ 32'h0100, 32'h0, 1'h0, 1'h1);
		xact(4'hB, sc_addr(8'h30) ^ 32'h0001, 32'h0, 1'h0, 1'h1);
		set_bus(8'h24, 8'h20, 8'h2F);
		xact(4'hB, sc_addr(8'h24), 32'h0, 1'h0, 1'h0);
		xact(4'hB, sc_addr(8'h2F), 32'h0, 1'h0, 1'h0);
		$display("test special requests done");
		// random traffic, half the configuration writes shaped as requests
		set_bus(8'($urandom), 8'h40, 8'h7F);
		repeat (100) begin
			logic [3:0] c;
			logic [31:0] a;
			c = 4'($urandom);
			a = $urandom;
			if (c == 4'hB && $urandom % 2) a = sc_addr(8'($urandom));
			xact(c, a, $urandom, $urandom % 4 == 0, 1'($urandom % 2));
		end
		$display("test random done");
		report_and_stop();
	end
endmodule // tb_top
